// ==== cltd_core.v ====
`timescale 1ns/1ps
// What this block does
// - 1110 0xxx: conditional jump on zero, carry, overflow, negative; bit 8 inverts
// - 1101: bit 11 clear relative jump, set relative call pushing return address
// - absolute jump and call take two words and two cycles, second word 1111
// - words 1111 xxxx and all-zero word are one-cycle no-operations
// - taken conditional jump costs two cycles, second one an inserted no-operation
// - interrupt return pops address, re-enables interrupts, s restores shadow copies
// - subroutine return pops stack top into program counter, s fast restore
// - return with literal loads accumulator and returns in two cycles
// - push saves return address, pop discards stack top, one cycle each
// - watchdog clear resets watchdog, sets watchdog-expired and power-down flags
// - sleep enters standby and updates watchdog-expired and power-down flags
// - all-ones low byte word resets core registers except shadow copies, second-word latches and payload outputs in one cycle
// - literal add and literal subtract update accumulator and all five flags
// - literal and, or, xor update accumulator, zero and negative only
// - literal load into accumulator, flags untouched
// - literal multiply into product register, flags untouched
// - 4-bit literal loaded into bank select register bits 3:0
// - two-word load of 12-bit literal into indirect pointer f
// - table read, two cycles, four pointer modes
// - table write, same modes; a started memory write runs until it ends
// - read-modify-write of a port takes the pin levels as source
// - timer zero write clears the prescaler when assigned to it
`include "cltd_regs.vh"
module cltd_core #(
	parameter PC_W = 20,
	parameter TP_W = 22
) (
	input  wire            hclk,
	input  wire            hresetn,
	input  wire            hsel,
	input  wire [31:0]     haddr,
	input  wire [1:0]      htrans,
	input  wire            hwrite,
	input  wire [2:0]      hsize,
	input  wire [31:0]     hwdata,
	input  wire            hready,
	output reg  [31:0]     hrdata,
	output wire            hreadyout,
	output wire            hresp,
	output wire [PC_W-1:0] instr_addr,
	input  wire [15:0]     instr_data,
	input  wire            instr_valid,
	output reg             stack_push,
	output reg  [PC_W-1:0] stack_push_addr,
	output reg             stack_pop,
	input  wire [PC_W-1:0] stack_top,
	output reg             tbl_rd_req,
	output reg             tbl_wr_req,
	output reg  [TP_W-1:0] tbl_addr,
	output reg  [7:0]      tbl_wdata,
	input  wire [7:0]      tbl_rdata,
	input  wire            tbl_wr_busy,
	output reg             watchdog_clear,
	output reg             sleep_enter,
	input  wire            wake,
	input  wire            wdt_timeout,
	output reg             soft_reset,
	input  wire            rmw_port_sel,
	input  wire [7:0]      rmw_latch,
	input  wire [7:0]      rmw_pin_levels,
	output wire [7:0]      rmw_source,
	input  wire            timer_zero_write,
	output reg             prescaler_clear
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam [4:0] ST_EXEC  = 5'b00001;
	localparam [4:0] ST_FLUSH = 5'b00010;
	localparam [4:0] ST_WORD2 = 5'b00100;
	localparam [4:0] ST_TBL   = 5'b01000;
	localparam [4:0] ST_TWAIT = 5'b10000;
	localparam [1:0] W2_ABSOLUTE_JUMP  = 2'd0;
	localparam [1:0] W2_CALL  = 2'd1;
	localparam [1:0] W2_PTR   = 2'd2;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// add with carry in: {ov, dc, c, sum}
	function [10:0] cltd_add;
		input [7:0] a;
		input [7:0] b;
		input       cin;
		reg   [8:0] s;
		reg   [4:0] l;
		begin
			s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			cltd_add = {(a[7] == b[7]) && (s[7] != a[7]), l[4], s[8], s[7:0]};
		end
	endfunction

	// next table pointer for the two mode bits
	function [TP_W-1:0] cltd_tp_next;
		input [TP_W-1:0] p;
		input [1:0]      m;
		begin
			case (m)
				2'd1:    cltd_tp_next = p + {{(TP_W-1){1'b0}}, 1'b1};
				2'd2:    cltd_tp_next = p - {{(TP_W-1){1'b0}}, 1'b1};
				2'd3:    cltd_tp_next = p + {{(TP_W-1){1'b0}}, 1'b1};
				default: cltd_tp_next = p;
			endcase
		end
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg  [4:0]      state;
	reg  [PC_W-1:0] pc;
	reg  [7:0]      acc;
	reg  [4:0]      flags;
	reg  [3:0]      bank;
	reg  [4:0]      ctrl;
	reg  [15:0]     prod;
	reg  [11:0]     ptr0;
	reg  [11:0]     ptr1;
	reg  [11:0]     ptr2;
	reg  [TP_W-1:0] tblptr;
	reg  [7:0]      tablat;
	reg             wdt_flag;
	reg             pd_flag;
	reg             asleep;
	reg  [1:0]      w2_kind;
	reg  [7:0]      w1_low;
	reg  [7:0]      sh_acc;
	reg  [4:0]      sh_flags;
	reg  [3:0]      sh_bank;
	reg             sw_rst;
	reg             ahb_wr_pend;
	reg  [7:0]      ahb_wr_addr;
	reg  [31:0]     rd_mux;
	reg             flag_sel;

	wire [15:0]     w = instr_data;
	wire [PC_W-1:0] pc_next = pc + {{(PC_W-1){1'b0}}, 1'b1};
	// offsets are word counts from the following instruction
	wire [PC_W-1:0] off8  = {{(PC_W-8){w[7]}}, w[7:0]};
	wire [PC_W-1:0] off11 = {{(PC_W-11){w[10]}}, w[10:0]};
	wire [10:0]     add_r = cltd_add(acc, w[7:0], 1'b0);
	wire [10:0]     sub_r = cltd_add(w[7:0], ~acc, 1'b1);
	wire            run = ctrl[`CLTD_CTRL_RUN] & ~asleep & ~sw_rst;
	wire            go = run & instr_valid;
	wire [7:0]      logic_r = (w[11:8] == `CLTD_OP_AND) ? (acc & w[7:0]) :
	                          (w[11:8] == `CLTD_OP_IOR) ? (acc | w[7:0]) : (acc ^ w[7:0]);
	wire [7:0]      daw_lo = (acc[3:0] > 4'h9 || flags[`CLTD_FLAG_DC]) ? 8'h06 : 8'h00;
	wire [7:0]      daw_hi = (acc[7:4] > 4'h9 || flags[`CLTD_FLAG_C]) ? 8'h60 : 8'h00;
	wire [8:0]      daw_r = {1'b0, acc} + {1'b0, daw_lo} + {1'b0, daw_hi};

	assign instr_addr = pc;
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	// pins, not the output latch, feed a port rewrite
	assign rmw_source = rmw_port_sel ? rmw_pin_levels : rmw_latch;

	// condition flag picked by bits 10:9
	always @* begin
		case (w[10:9])
			2'd0:    flag_sel = flags[`CLTD_FLAG_Z];
			2'd1:    flag_sel = flags[`CLTD_FLAG_C];
			2'd2:    flag_sel = flags[`CLTD_FLAG_OV];
			default: flag_sel = flags[`CLTD_FLAG_N];
		endcase
	end

	// ----------------------------------------
	// bus slave, zero wait states
	// ----------------------------------------
	// register read mux on the address phase
	always @* begin
		rd_mux = 32'h00000000;
		case (haddr[7:0])
			`CLTD_CTRL_OFS:   rd_mux = {27'h0000000, ctrl};
			`CLTD_STATUS_OFS: rd_mux = {19'h00000, state, asleep, pd_flag, wdt_flag, flags};
			`CLTD_ACC_OFS:    rd_mux = {24'h000000, acc};
			`CLTD_BANK_OFS:   rd_mux = {28'h0000000, bank};
			`CLTD_PC_OFS:     rd_mux = {{(32-PC_W){1'b0}}, pc};
			`CLTD_TBLPTR_OFS: rd_mux = {{(32-TP_W){1'b0}}, tblptr};
			`CLTD_TABLAT_OFS: rd_mux = {24'h000000, tablat};
			`CLTD_PROD_OFS:   rd_mux = {16'h0000, prod};
			`CLTD_PTR0_OFS:   rd_mux = {20'h00000, ptr0};
			`CLTD_PTR1_OFS:   rd_mux = {20'h00000, ptr1};
			`CLTD_PTR2_OFS:   rd_mux = {20'h00000, ptr2};
			default:          rd_mux = 32'h00000000;
		endcase
	end

	// capture address phase; read data stands in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata      <= 32'h00000000;
			ahb_wr_pend <= 1'b0;
			ahb_wr_addr <= 8'h00;
		end else if (hready) begin
			ahb_wr_pend <= hsel & htrans[1] & hwrite;
			ahb_wr_addr <= haddr[7:0];
			if (hsel && htrans[1] && !hwrite)
				hrdata <= rd_mux;
		end
	end

	// ----------------------------------------
	// execution
	// ----------------------------------------
	// one process so the software reset reaches the core registers except shadow copies, second-word latches and payload outputs
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_EXEC;
			pc <= {PC_W{1'b0}};
			acc <= `CLTD_ACC_RST;
			flags <= `CLTD_FLAGS_RST;
			bank <= 4'h0;
			ctrl <= `CLTD_CTRL_RST;
			prod <= 16'h0000;
			ptr0 <= 12'h000;
			ptr1 <= 12'h000;
			ptr2 <= 12'h000;
			tblptr <= {TP_W{1'b0}};
			tablat <= 8'h00;
			wdt_flag <= `CLTD_WDT_RST;
			pd_flag <= `CLTD_PD_RST;
			asleep <= 1'b0;
			w2_kind <= W2_ABSOLUTE_JUMP;
			w1_low <= 8'h00;
			sh_acc <= 8'h00;
			sh_flags <= 5'h00;
			sh_bank <= 4'h0;
			sw_rst <= 1'b0;
			soft_reset <= 1'b0;
			stack_push <= 1'b0;
			stack_push_addr <= {PC_W{1'b0}};
			stack_pop <= 1'b0;
			tbl_rd_req <= 1'b0;
			tbl_wr_req <= 1'b0;
			tbl_addr <= {TP_W{1'b0}};
			tbl_wdata <= 8'h00;
			watchdog_clear <= 1'b0;
			sleep_enter <= 1'b0;
			prescaler_clear <= 1'b0;
		end else if (sw_rst) begin
			// core reset, bar shadow copies, second-word latches and payloads, one cycle after the word ran
			state <= ST_EXEC;
			pc <= {PC_W{1'b0}};
			acc <= `CLTD_ACC_RST;
			flags <= `CLTD_FLAGS_RST;
			bank <= 4'h0;
			ctrl <= `CLTD_CTRL_RST;
			prod <= 16'h0000;
			ptr0 <= 12'h000;
			ptr1 <= 12'h000;
			ptr2 <= 12'h000;
			tblptr <= {TP_W{1'b0}};
			tablat <= 8'h00;
			wdt_flag <= `CLTD_WDT_RST;
			pd_flag <= `CLTD_PD_RST;
			asleep <= 1'b0;
			sw_rst <= 1'b0;
			soft_reset <= 1'b0;
			stack_push <= 1'b0;
			stack_pop <= 1'b0;
			tbl_rd_req <= 1'b0;
			tbl_wr_req <= 1'b0;
			watchdog_clear <= 1'b0;
			sleep_enter <= 1'b0;
			prescaler_clear <= 1'b0;
		end else begin
			stack_push <= 1'b0;
			stack_pop <= 1'b0;
			tbl_rd_req <= 1'b0;
			tbl_wr_req <= 1'b0;
			watchdog_clear <= 1'b0;
			sleep_enter <= 1'b0;
			prescaler_clear <= timer_zero_write & ctrl[`CLTD_CTRL_PSA];
			if (wdt_timeout)
				wdt_flag <= 1'b0;
			if (wake)
				asleep <= 1'b0;
			case (state)
				ST_EXEC: if (go) begin
					pc <= pc_next;
					if (w[15:11] == 5'b11100) begin
						// taken jump adds the inserted no-operation cycle
						if (flag_sel ^ w[8]) begin
							pc <= pc_next + off8;
							state <= ST_FLUSH;
						end
					end else if (w[15:12] == 4'hD) begin
						pc <= pc_next + off11;
						state <= ST_FLUSH;
						if (w[11]) begin
							stack_push <= 1'b1;
							stack_push_addr <= pc_next;
						end
					end else if (w[15:8] == 8'hEF) begin
						w2_kind <= W2_ABSOLUTE_JUMP;
						w1_low <= w[7:0];
						state <= ST_WORD2;
					end else if (w[15:9] == 7'b1110110) begin
						w2_kind <= W2_CALL;
						w1_low <= w[7:0];
						state <= ST_WORD2;
						if (w[8]) begin
							sh_acc <= acc;
							sh_flags <= flags;
							sh_bank <= bank;
						end
					end else if (w[15:6] == 10'b1110111000) begin
						w2_kind <= W2_PTR;
						w1_low <= w[7:0];
						state <= ST_WORD2;
					end else if (w[15:8] == 8'h00) begin
						case (w[7:0])
							`CLTD_MISC_SLEEP: begin
								sleep_enter <= 1'b1;
								asleep <= 1'b1;
								wdt_flag <= 1'b1;
								pd_flag <= 1'b0;
							end
							`CLTD_MISC_WDT: begin
								watchdog_clear <= 1'b1;
								wdt_flag <= 1'b1;
								pd_flag <= 1'b1;
							end
							`CLTD_MISC_PUSH: begin
								stack_push <= 1'b1;
								stack_push_addr <= pc_next;
							end
							`CLTD_MISC_POP: stack_pop <= 1'b1;
							`CLTD_MISC_DAW: begin
								acc <= daw_r[7:0];
								flags[`CLTD_FLAG_C] <= daw_r[8] | flags[`CLTD_FLAG_C];
							end
							8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F: begin
								// pre-increment moves the pointer before the access
								tbl_addr <= (w[1:0] == 2'd3) ? cltd_tp_next(tblptr, 2'd3)
								                             : tblptr;
								tblptr <= cltd_tp_next(tblptr, w[1:0]);
								tbl_rd_req <= ~w[2];
								tbl_wr_req <= w[2];
								tbl_wdata <= tablat;
								state <= w[2] ? ST_TWAIT : ST_TBL;
							end
							8'h10, 8'h11: begin
								pc <= stack_top;
								stack_pop <= 1'b1;
								state <= ST_FLUSH;
								if (!ctrl[`CLTD_CTRL_PRIO] || !ctrl[`CLTD_CTRL_IRQ_HI])
									ctrl[`CLTD_CTRL_IRQ_HI] <= 1'b1;
								else
									ctrl[`CLTD_CTRL_IRQ_LO] <= 1'b1;
								if (w[0]) begin
									acc <= sh_acc;
									flags <= sh_flags;
									bank <= sh_bank;
								end
							end
							8'h12, 8'h13: begin
								pc <= stack_top;
								stack_pop <= 1'b1;
								state <= ST_FLUSH;
								if (w[0]) begin
									acc <= sh_acc;
									flags <= sh_flags;
									bank <= sh_bank;
								end
							end
							`CLTD_MISC_RESET: begin
								sw_rst <= 1'b1;
								soft_reset <= 1'b1;
							end
							default: ;
						endcase
					end else if (w[15:8] == 8'h01) begin
						if (w[7:4] == 4'h0)
							bank <= w[3:0];
					end else if (w[15:12] == 4'h0 && w[11]) begin
						case (w[11:8])
							`CLTD_OP_ADD: begin
								acc <= add_r[7:0];
								flags <= {add_r[7], add_r[10], add_r[7:0] == 8'h00,
								          add_r[9], add_r[8]};
							end
							`CLTD_OP_SUB: begin
								acc <= sub_r[7:0];
								flags <= {sub_r[7], sub_r[10], sub_r[7:0] == 8'h00,
								          sub_r[9], sub_r[8]};
							end
							`CLTD_OP_AND, `CLTD_OP_IOR, `CLTD_OP_XOR: begin
								acc <= logic_r;
								flags[`CLTD_FLAG_Z] <= (logic_r == 8'h00);
								flags[`CLTD_FLAG_N] <= logic_r[7];
							end
							`CLTD_OP_MOV: acc <= w[7:0];
							`CLTD_OP_MUL: prod <= acc * w[7:0];
							`CLTD_OP_RETK: begin
								acc <= w[7:0];
								pc <= stack_top;
								stack_pop <= 1'b1;
								state <= ST_FLUSH;
							end
							default: ;
						endcase
					end
					// 1111 words and unknown codes fall through as no-operations
				end
				ST_FLUSH: state <= ST_EXEC;
				ST_WORD2: if (go) begin
					// second word is consumed here, never run on its own
					state <= ST_EXEC;
					pc <= pc_next;
					case (w2_kind)
						W2_ABSOLUTE_JUMP: pc <= {w[11:0], w1_low};
						W2_CALL: begin
							pc <= {w[11:0], w1_low};
							stack_push <= 1'b1;
							stack_push_addr <= pc_next;
						end
						W2_PTR: case (w1_low[5:4])
							2'd0:    ptr0 <= {w1_low[3:0], w[7:0]};
							2'd1:    ptr1 <= {w1_low[3:0], w[7:0]};
							default: ptr2 <= {w1_low[3:0], w[7:0]};
						endcase
						default: ;
					endcase
				end
				ST_TBL: begin
					tablat <= tbl_rdata;
					state <= ST_EXEC;
				end
				// a started memory write is held until the memory ends it
				ST_TWAIT: if (!tbl_wr_busy && !tbl_wr_req)
					state <= ST_EXEC;
				default: state <= ST_EXEC;
			endcase
			// software writes take priority over the core in the same cycle
			if (ahb_wr_pend) begin
				case (ahb_wr_addr)
					`CLTD_CTRL_OFS:   ctrl <= hwdata[`CLTD_CTRL_W-1:0];
					`CLTD_ACC_OFS:    acc <= hwdata[7:0];
					`CLTD_BANK_OFS:   bank <= hwdata[3:0];
					`CLTD_PC_OFS:     pc <= hwdata[PC_W-1:0];
					`CLTD_TBLPTR_OFS: tblptr <= hwdata[TP_W-1:0];
					`CLTD_TABLAT_OFS: tablat <= hwdata[7:0];
					default: ;
				endcase
			end
		end
	end
endmodule // cltd_core

// ==== cltd_regs.vh ====
`ifndef CLTD_REGS_VH
`define CLTD_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CLTD_CTRL_OFS    8'h00
`define CLTD_STATUS_OFS  8'h04
`define CLTD_ACC_OFS     8'h08
`define CLTD_BANK_OFS    8'h0C
`define CLTD_PC_OFS      8'h10
`define CLTD_TBLPTR_OFS  8'h14
`define CLTD_TABLAT_OFS  8'h18
`define CLTD_PROD_OFS    8'h1C
`define CLTD_PTR0_OFS    8'h20
`define CLTD_PTR1_OFS    8'h24
`define CLTD_PTR2_OFS    8'h28
// ----------------------------------------
// control field positions
// ----------------------------------------
`define CLTD_CTRL_RUN    0
`define CLTD_CTRL_PRIO   1
`define CLTD_CTRL_PSA    2
`define CLTD_CTRL_IRQ_HI 3
`define CLTD_CTRL_IRQ_LO 4
`define CLTD_CTRL_W      5
// ----------------------------------------
// status field positions
// ----------------------------------------
`define CLTD_FLAG_C      0
`define CLTD_FLAG_DC     1
`define CLTD_FLAG_Z      2
`define CLTD_FLAG_OV     3
`define CLTD_FLAG_N      4
`define CLTD_STAT_WDT    5
`define CLTD_STAT_PD     6
`define CLTD_STAT_SLEEP  7
`define CLTD_STAT_STATE  8
// ----------------------------------------
// reset values
// ----------------------------------------
`define CLTD_CTRL_RST    5'h00
`define CLTD_FLAGS_RST   5'h00
`define CLTD_ACC_RST     8'h00
`define CLTD_WDT_RST     1'b1
`define CLTD_PD_RST      1'b1
// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define CLTD_OP_ADD      4'hF
`define CLTD_OP_SUB      4'h8
`define CLTD_OP_AND      4'hB
`define CLTD_OP_IOR      4'h9
`define CLTD_OP_XOR      4'hA
`define CLTD_OP_MOV      4'hE
`define CLTD_OP_MUL      4'hD
`define CLTD_OP_RETK     4'hC
`define CLTD_MISC_SLEEP  8'h03
`define CLTD_MISC_WDT    8'h04
`define CLTD_MISC_PUSH   8'h05
`define CLTD_MISC_POP    8'h06
`define CLTD_MISC_DAW    8'h07
`define CLTD_MISC_RESET  8'hFF
`endif

// ==== cltd_core_assertions.sv ====
`timescale 1ns/1ps
// ------
// port-level checks of the decoder
// ------
module cltd_chk #(
	parameter PC_W = 20,
	parameter TP_W = 22
) (
	input wire            hclk,
	input wire            hresetn,
	input wire            hreadyout,
	input wire            hresp,
	input wire [PC_W-1:0] instr_addr,
	input wire            tbl_rd_req,
	input wire            tbl_wr_req,
	input wire [TP_W-1:0] tbl_addr,
	input wire [7:0]      tbl_wdata,
	input wire            tbl_wr_busy,
	input wire            watchdog_clear,
	input wire            sleep_enter,
	input wire            wake,
	input wire            soft_reset,
	input wire            rmw_port_sel,
	input wire [7:0]      rmw_latch,
	input wire [7:0]      rmw_pin_levels,
	input wire [7:0]      rmw_source,
	input wire            timer_zero_write,
	input wire            prescaler_clear
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// standby entered and no wake seen for two cycles
	sequence s_nap;
		sleep_enter && !wake ##1 !wake;
	endsequence
	// a memory write handed over while memory is idle
	sequence s_wr_start;
		tbl_wr_req && !tbl_wr_busy;
	endsequence
	property p_bus;
		hreadyout && !hresp;
	endproperty
	property p_rmw;
		rmw_source == (rmw_port_sel ? rmw_pin_levels : rmw_latch);
	endproperty
	property p_presc;
		prescaler_clear |-> $past(timer_zero_write);
	endproperty
	property p_soft;
		soft_reset |=> (instr_addr == '0) [*2];
	endproperty
	property p_nap;
		s_nap |-> $stable(instr_addr);
	endproperty
	property p_wfree;
		tbl_wr_req |-> !tbl_wr_busy;
	endproperty
	// address and data must stand for the three cycles after a write is handed over
	property p_whold;
		s_wr_start |=> ($stable(tbl_addr) && $stable(tbl_wdata)) [*3];
	endproperty
	property p_wstall;
		tbl_wr_busy |=> $stable(instr_addr);
	endproperty
	property p_rd;
		tbl_rd_req |=> $stable(instr_addr) && !tbl_rd_req;
	endproperty
	property p_excl;
		watchdog_clear |-> !sleep_enter ##1 !watchdog_clear;
	endproperty
	a_bus: assert property (p_bus)
		else $error("bus answer not zero-wait okay");
	a_rmw: assert property (p_rmw)
		else $error("port source not taken from pins");
	a_presc: assert property (p_presc)
		else $error("prescaler cleared without timer write");
	a_soft: assert property (p_soft)
		else $error("fetch address not back to zero");
	a_nap: assert property (p_nap)
		else $error("fetch moved while in standby");
	a_wfree: assert property (p_wfree)
		else $error("write request while write runs");
	a_whold: assert property (p_whold)
		else $error("write address or data changed");
	a_wstall: assert property (p_wstall)
		else $error("fetch moved during memory write");
	a_rd: assert property (p_rd)
		else $error("table read not two cycles");
	a_excl: assert property (p_excl)
		else $error("watchdog clear pulse malformed");
endmodule // cltd_chk

bind cltd_core cltd_chk #(.PC_W(PC_W), .TP_W(TP_W)) u_chk (.hclk, .hresetn, .hreadyout,
	.hresp, .instr_addr, .tbl_rd_req, .tbl_wr_req, .tbl_addr, .tbl_wdata, .tbl_wr_busy,
	.watchdog_clear, .sleep_enter, .wake, .soft_reset, .rmw_port_sel, .rmw_latch,
	.rmw_pin_levels, .rmw_source, .timer_zero_write, .prescaler_clear);

// ==== cltd_mem.sv ====
`timescale 1ns/1ps
// ------
// program memory, return stack, table memory
// ------
module cltd_mem (
	input wire         hclk,
	input wire         hresetn,
	input wire         slow,
	input wire  [19:0] instr_addr,
	output wire [15:0] instr_data,
	output reg         instr_valid,
	input wire         stack_push,
	input wire  [19:0] stack_push_addr,
	input wire         stack_pop,
	output wire [19:0] stack_top,
	input wire         tbl_wr_req,
	input wire  [21:0] tbl_addr,
	input wire  [7:0]  tbl_wdata,
	output wire [7:0]  tbl_rdata,
	output wire        tbl_wr_busy
);
	logic [15:0] prog [0:63];
	logic [7:0]  tmem [0:255];
	logic [19:0] stk [0:31];
	logic [4:0]  sp;
	logic [3:0]  bcnt;
	// a stalled fetch shows a scrambled word so a held value is never trusted
	assign instr_data = instr_valid ? prog[instr_addr[5:0]] : ~prog[instr_addr[5:0]];
	assign stack_top = stk[sp - 5'h1];
	assign tbl_rdata = tmem[tbl_addr[7:0]];
	assign tbl_wr_busy = bcnt != 4'h0;
	// slow mode offers a word every other cycle and writes take longer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr_valid <= 1'b1;
			sp <= 5'h0;
			bcnt <= 4'h0;
		end else begin
			instr_valid <= !slow || !instr_valid;
			if (stack_push) begin
				stk[sp] <= stack_push_addr;
				sp <= sp + 5'h1;
			end
			if (stack_pop)
				sp <= sp - 5'h1;
			if (tbl_wr_req) begin
				tmem[tbl_addr[7:0]] <= tbl_wdata;
				bcnt <= slow ? 4'h9 : 4'h5;
			end else if (bcnt != 4'h0)
				bcnt <= bcnt - 4'h1;
		end
	end
endmodule // cltd_mem

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "cltd_regs.vh"
module testbench;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, instr_valid, slow;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [19:0] instr_addr, stack_push_addr, stack_top;
	logic [15:0] instr_data;
	logic        stack_push, stack_pop, tbl_rd_req, tbl_wr_req, tbl_wr_busy, wake;
	logic        watchdog_clear, sleep_enter, wdt_timeout, soft_reset, rmw_port_sel;
	logic        timer_zero_write, prescaler_clear;
	logic [21:0] tbl_addr;
	logic [7:0]  tbl_wdata, tbl_rdata, rmw_latch, rmw_pin_levels, rmw_source;
	int          fail_count = 0;
	int          n_checks = 0;
	// ------
	// clock, design, far side
	// ------
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	assign hready = hreadyout;
	cltd_core i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .instr_addr, .instr_data, .instr_valid,
		.stack_push, .stack_push_addr, .stack_pop, .stack_top, .tbl_rd_req, .tbl_wr_req,
		.tbl_addr, .tbl_wdata, .tbl_rdata, .tbl_wr_busy, .watchdog_clear, .sleep_enter,
		.wake, .wdt_timeout, .soft_reset, .rmw_port_sel, .rmw_latch, .rmw_pin_levels,
		.rmw_source, .timer_zero_write, .prescaler_clear);
	cltd_mem i_mem (.hclk, .hresetn, .slow, .instr_addr, .instr_data, .instr_valid,
		.stack_push, .stack_push_addr, .stack_pop, .stack_top, .tbl_wr_req, .tbl_addr,
		.tbl_wdata, .tbl_rdata, .tbl_wr_busy);
	// side pins stirred every cycle so their paths are exercised
	always @(posedge hclk) begin
		timer_zero_write <= 2'($urandom) == 2'h0;
		rmw_port_sel <= 1'($urandom);
		rmw_latch <= 8'($urandom);
		rmw_pin_levels <= 8'($urandom);
	end
	// ------
	// bus and checking tasks
	// ------
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one single transfer; waits on hready, no fixed latency assumed
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
		hsel <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task rd(input logic [7:0] a, output logic [31:0] r);
		xfer(1'b0, a, 32'h0, r);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		rd(a, r);
		check(r, e);
	endtask
	task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		logic [31:0] r;
		for (int n = 0; n < 80; n++) begin
			rd(a, r);
			if ((r & m) === v)
				break;
		end
		check(r & m, v);
	endtask
	// reference result {n, ov, z, dc, c, acc} of one literal operation
	function automatic logic [12:0] alu(input logic [3:0] op, input logic [7:0] a, k,
		input logic [4:0] f);
		int r;
		logic [7:0] y;
		logic [4:0] g;
		g = f;
		y = a;
		r = 0;
		case (op)
			4'hF: begin
				r = a + k;
				y = r[7:0];
				g[0] = r > 255;
				g[1] = a[3:0] + k[3:0] > 15;
				g[3] = a[7] == k[7] && y[7] != a[7];
			end
			4'h8: begin
				r = k - a;
				y = r[7:0];
				g[0] = k >= a;
				g[1] = k[3:0] >= a[3:0];
				g[3] = k[7] != a[7] && y[7] != k[7];
			end
			4'hB: y = a & k;
			4'h9: y = a | k;
			4'hA: y = a ^ k;
			4'hE: y = k;
			default: ;
		endcase
		if (op != 4'hE && op != 4'hD) begin
			g[2] = y == 8'h0;
			g[4] = y[7];
		end
		return {g, y};
	endfunction
	// ------
	// scenarios
	// ------
	initial begin : main
		logic [31:0] r;
		logic [12:0] e;
		logic [15:0] pe;
		logic [15:0] pg [33];
		logic [3:0]  ops [7];
		logic [3:0]  op;
		logic [2:0]  code;
		logic [7:0]  a, k, t, tv;
		logic        tk;
		ops = '{4'hF, 4'h8, 4'hB, 4'h9, 4'hA, 4'hE, 4'hD};
		void'($urandom(59));
		{hsel, hwrite, slow, wake, wdt_timeout} = 5'h0;
		{haddr, hwdata, htrans} = 66'h0;
		hsize = 3'h2;
		hresetn = 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		// reset values, read-only and unmapped places
		rc(`CLTD_CTRL_OFS, 32'h0);
		rd(`CLTD_STATUS_OFS, r);
		check(r & 32'hFF, 32'h60);
		rc(`CLTD_ACC_OFS, 32'h0);
		wr(`CLTD_PROD_OFS, 32'hFFFF);
		rc(`CLTD_PROD_OFS, 32'h0);
		rc(8'h40, 32'h0);
		pe = 16'h0;
		// literal op then each conditional jump kind, fetch alternately slow
		for (int i = 0; i < 16; i++) begin
			op = ops[i % 7];
			code = 3'(i);
			a = 8'($urandom);
			k = 8'($urandom);
			slow <= i[0];
			i_mem.prog[0] = {4'h0, op, k};
			i_mem.prog[1] = {5'h1C, code, 8'h02};
			i_mem.prog[2] = 16'hD7FF;
			i_mem.prog[3] = 16'hFA5A;
			i_mem.prog[4] = 16'hD7FF;
			wr(`CLTD_PC_OFS, 32'h0);
			wr(`CLTD_ACC_OFS, {24'h0, a});
			rd(`CLTD_STATUS_OFS, r);
			e = alu(op, a, k, r[4:0]);
			if (op == 4'hD)
				pe = a * k;
			case (code[2:1])
				2'h0: tk = e[10];
				2'h1: tk = e[8];
				2'h2: tk = e[11];
				default: tk = e[12];
			endcase
			tk = tk ^ code[0];
			wr(`CLTD_CTRL_OFS, 32'h5);
			poll(`CLTD_PC_OFS, 32'hFFFFF, tk ? 32'h4 : 32'h2);
			wr(`CLTD_CTRL_OFS, 32'h0);
			rc(`CLTD_PC_OFS, tk ? 32'h4 : 32'h2);
			rc(`CLTD_ACC_OFS, {24'h0, e[7:0]});
			rd(`CLTD_STATUS_OFS, r);
			check(r & 32'h1F, {27'h0, e[12:8]});
			rc(`CLTD_PROD_OFS, {16'h0, pe});
		end
		// calls, returns, stack, standby, pointer and table transfers
		pg = '{16'hD804, 16'hEC0A, 16'hF000, 16'hEF14, 16'hF000, 16'h0C5A, 16'hFFFF,
			16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0012, 16'hFFFF, 16'hFFFF, 16'hFFFF,
			16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0005,
			16'h0006, 16'hD801, 16'hD001, 16'h0010, 16'h0003, 16'h0004, 16'h0107,
			16'hEE13, 16'hF0AB, 16'h0009, 16'h000F, 16'hD7FF};
		for (int j = 0; j < 33; j++)
			i_mem.prog[j] = pg[j];
		t = 8'($urandom % 200);
		tv = 8'($urandom);
		i_mem.tmem[t] = tv;
		i_mem.tmem[t + 8'h2] = ~tv;
		slow <= 1'b1;
		wr(`CLTD_PC_OFS, 32'h0);
		wr(`CLTD_TBLPTR_OFS, {24'h0, t});
		wr(`CLTD_CTRL_OFS, 32'h1);
		poll(`CLTD_STATUS_OFS, 32'h80, 32'h80);
		rd(`CLTD_STATUS_OFS, r);
		check(r & 32'h60, 32'h20);
		rc(`CLTD_CTRL_OFS, 32'h9);
		rc(`CLTD_PC_OFS, 32'h1A);
		wdt_timeout <= 1'b1;
		@(posedge hclk);
		wdt_timeout <= 1'b0;
		rd(`CLTD_STATUS_OFS, r);
		check(r & 32'h20, 32'h0);
		wake <= 1'b1;
		@(posedge hclk);
		wake <= 1'b0;
		poll(`CLTD_PC_OFS, 32'hFFFFF, 32'h20);
		wr(`CLTD_CTRL_OFS, 32'h0);
		rc(`CLTD_PC_OFS, 32'h20);
		rc(`CLTD_ACC_OFS, 32'h5A);
		rc(`CLTD_BANK_OFS, 32'h7);
		rc(`CLTD_PTR1_OFS, 32'h3AB);
		rc(`CLTD_TABLAT_OFS, {24'h0, tv});
		rc(`CLTD_TBLPTR_OFS, {24'h0, t + 8'h2});
		check({24'h0, i_mem.tmem[t + 8'h2]}, {24'h0, tv});
		check({27'h0, i_mem.sp}, 32'h0);
		rd(`CLTD_STATUS_OFS, r);
		check(r & 32'h60, 32'h60);
		// software reset word restores the reset state
		wr(`CLTD_ACC_OFS, 32'h77);
		i_mem.prog[0] = 16'h00FF;
		wr(`CLTD_PC_OFS, 32'h0);
		wr(`CLTD_CTRL_OFS, 32'h1);
		poll(`CLTD_CTRL_OFS, 32'h1, 32'h0);
		rc(`CLTD_ACC_OFS, 32'h0);
		rc(`CLTD_PC_OFS, 32'h0);
		close_out;
	end
	// hang guard at 30000 clock periods, far beyond the fewer than a thousand cycles the run needs
	initial begin
		#(40 * 30000);
		fail_count++;
		close_out;
	end
endmodule // testbench
